//--- src/ipu_regs.vh
/*
  Constants of the interrupt priority unit: port selects, command word bit
  positions, second command word action codes and reset values.
  Assumes it is included by bare name from each design file that needs it.
*/
// Function
// - A low-port write with bit 4 set starts initialization afresh.
// - That word clears mask, makes level 7 lowest, clears special mask, selects requests.
// - The second initialization byte is required but its value is ignored.
// - Bit 0 of the first word says whether a fourth word follows.
// - Writing the fourth word to the high port ends initialization.
// - Fourth word bit 0 selects processor mode, bit 1 automatic end of service.
// - High-port writes after initialization load mask bits; high-port reads return them.
// - Second word: bit 7 rotate, bit 6 level enable, bit 5 end, bits 2-0 level.
// - Non-specific end clears the highest-priority in-service bit.
// - Specific end clears the in-service bit named by the level field.
// - Rotate with non-specific end clears top in-service bit and makes it lowest.
// - Rotate-in-automatic setting rotates priority after each acknowledge read in automatic end mode.
// - Rotate with specific end clears the named bit and makes it lowest.
// - Set-priority makes the named level lowest, others follow circularly.
// - Third word: bit 6 enables bit 5 to select special or normal masking.
// - Third word bit 2 makes the next low read return the poll result.
// - Without poll, bit 1 selects next low read: requests or in-service by bit 0.
// - Poll and register-read together: poll wins, register-read selection ignored.
// - Command words are accepted at any time once initialization completes.
// - Poll read returns level in bits 2-0, sets in-service, clears request.
// - Level 0 highest by default; in-service bit inhibits equal or lower requests, only equal ones under special masking.
// - With no request pending at a poll read, level 7 is reported.
// - In automatic end mode the poll read does not set the in-service bit.
`ifndef IPU_REGS_VH
`define IPU_REGS_VH

// ----------------------------------------------------------------------
// Port selects
// ----------------------------------------------------------------------
`define IPU_PORT_LOW          1'b0
`define IPU_PORT_HIGH         1'b1

// ----------------------------------------------------------------------
// Command word bit positions
// ----------------------------------------------------------------------
`define IPU_CW1_START_BIT     4
`define IPU_CW1_NEED4_BIT     0
`define IPU_CW4_UPM_BIT       1'b0
`define IPU_CW4_AUTO_END_OF_SERVICE_BIT      1
`define IPU_OCW_SEL_BIT       3
`define IPU_EOI_ROTATION_COMMAND_WORD_ACT_MSB      7
`define IPU_EOI_ROTATION_COMMAND_WORD_ACT_LSB      5
`define IPU_MASK_MODE_READ_SELECT_WORD_SPECIAL_MASKING_WRITE_ENABLE_BIT     6
`define IPU_MASK_MODE_READ_SELECT_WORD_SMM_BIT      5
`define IPU_MASK_MODE_READ_SELECT_WORD_POLL_BIT     2
`define IPU_MASK_MODE_READ_SELECT_WORD_RR_BIT       1
`define IPU_MASK_MODE_READ_SELECT_WORD_RIS_BIT      0

// ----------------------------------------------------------------------
// Second command word actions (rotate, level enable, end)
// ----------------------------------------------------------------------
`define IPU_ACT_ROT_AUTO_END_OF_SERVICE_CLR  3'h0
`define IPU_ACT_NS_EOI        3'h1
`define IPU_ACT_SP_EOI        3'h3
`define IPU_ACT_ROT_AUTO_END_OF_SERVICE_SET  3'h4
`define IPU_ACT_ROT_NS_EOI    3'h5
`define IPU_ACT_SET_PRIO      3'h6
`define IPU_ACT_ROT_SP_EOI    3'h7

// ----------------------------------------------------------------------
// Reset and initialization values
// ----------------------------------------------------------------------
`define IPU_MASK_RST          8'h00
`define IPU_LOWEST_RST        3'h7
`define IPU_SLAVE_ADDR_RST    3'h7
`define IPU_NO_REQ_LEVEL      3'h7
`define IPU_READ_IRR          1'b0
`define IPU_READ_ISR          1'b1

`endif

//--- src/ipu_resolver.v
/*
  Priority resolver of the interrupt priority unit: finds the winning
  request and the highest-priority in-service level under rotated priority.
  Assumes purely combinational use inside ipu_core on one clock.
*/
`timescale 1ns/1ns
`include "ipu_regs.vh"
module ipu_resolver
(
  // Pending state
  input  wire [7:0] req,
  input  wire [7:0] in_service_register,
  // Priority and masking mode
  input  wire [2:0] lowest,
  input  wire       special_masking_select,
  // Results
  output reg        win_valid,
  output reg  [2:0] win_lvl,
  output reg        isr_valid,
  output reg  [2:0] isr_lvl
);

  reg   [3:0] k;
  reg   [2:0] lvl;
  reg         blocked;

  // ----------------------------------------------------------------------
  // Scan from highest priority (just above lowest) down to lowest
  // ----------------------------------------------------------------------
  always @*
  begin
    win_valid = 1'b0;
    win_lvl   = `IPU_NO_REQ_LEVEL;
    isr_valid = 1'b0;
    isr_lvl   = 3'h0;
    blocked   = 1'b0;
    lvl       = 3'h0;
    for (k = 4'h1; k <= 4'h8; k = k + 4'h1)
    begin
      lvl = lowest + k[2:0];
      // An in-service level blocks itself and, when nested, all below it.
      if (in_service_register[lvl] && !special_masking_select)
        blocked = 1'b1;
      if (!win_valid && !blocked && req[lvl] && !in_service_register[lvl])
      begin
        win_valid = 1'b1;
        win_lvl   = lvl;
      end
      if (!isr_valid && in_service_register[lvl])
      begin
        isr_valid = 1'b1;
        isr_lvl   = lvl;
      end
    end
  end

endmodule

//--- src/ipu_core.v
/*
  Interrupt priority unit: eight-level programmable interrupt controller
  with initialization words, masking, end-of-service, rotation and poll.
  Assumes the host bus strobes are synchronous to clk, one cycle wide,
  and never carry a read and a write in the same cycle.
*/
`timescale 1ns/1ns
`include "ipu_regs.vh"
module ipu_core
#(
  parameter LINES = 8
)
(
  // Clock, reset and enable
  input  wire             clk,
  input  wire             resetn,
  input  wire             ce,
  // Host byte ports
  input  wire             bus_cs,
  input  wire             bus_wr,
  input  wire             bus_rd,
  input  wire             bus_addr,
  input  wire [7:0]       bus_wdata,
  output reg  [7:0]       bus_rdata,
  // Request pins
  input  wire [LINES-1:0] request_lines,
  // Status outputs
  output reg              int_out,
  output reg              init_done,
  output reg              processor_mode_bit,
  output reg              auto_end_of_service
);

  // ----------------------------------------------------------------------
  // Initialization states
  // ----------------------------------------------------------------------
  localparam ST_IDLE   = 2'b00;
  localparam ST_SECOND = 2'b01;
  localparam ST_FOURTH = 2'b10;
  localparam ST_READY  = 2'b11;

  reg   [1:0]       state_q;
  reg   [1:0]       state_d;
  reg               need4_q;
  reg               need4_d;
  reg   [7:0]       mask_q;
  reg   [7:0]       mask_d;
  reg   [7:0]       irr_q;
  reg   [7:0]       irr_d;
  reg   [7:0]       isr_q;
  reg   [7:0]       isr_d;
  reg   [2:0]       lowest_q;
  reg   [2:0]       lowest_d;
  reg               smm_q;
  reg               smm_d;
  reg               read_sel_q;
  reg               read_sel_d;
  reg               poll_q;
  reg               poll_d;
  reg               rot_auto_end_of_service_q;
  reg               rot_auto_end_of_service_d;
  reg               upm_q;
  reg               upm_d;
  reg               auto_end_of_service_q;
  reg               auto_end_of_service_d;
  reg   [7:0]       rdata_q;
  reg   [7:0]       rdata_d;
  reg               int_q;
  reg               int_d;
  reg               done_q;

  reg   [7:0]       irr_set;
  reg   [7:0]       irr_clr;
  reg   [7:0]       isr_set;
  reg   [7:0]       isr_clr;

  reg   [LINES-1:0] req_meta_q;
  reg   [LINES-1:0] req_sync_q;
  reg   [LINES-1:0] req_prev_q;
  wire  [7:0]       req_rise;

  wire              wr_low;
  wire              wr_high;
  wire              rd_low;
  wire              rd_high;
  wire  [2:0]       act;

  wire              win_valid;
  wire  [2:0]       win_lvl;
  wire              isr_valid;
  wire  [2:0]       isr_lvl;

  // ----------------------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------------------
  assign wr_low  = bus_cs & bus_wr & (bus_addr == `IPU_PORT_LOW);
  assign wr_high = bus_cs & bus_wr & (bus_addr == `IPU_PORT_HIGH);
  assign rd_low  = bus_cs & bus_rd & (bus_addr == `IPU_PORT_LOW);
  assign rd_high = bus_cs & bus_rd & (bus_addr == `IPU_PORT_HIGH);
  assign act     = bus_wdata[`IPU_EOI_ROTATION_COMMAND_WORD_ACT_MSB:`IPU_EOI_ROTATION_COMMAND_WORD_ACT_LSB];

  // ----------------------------------------------------------------------
  // Request pin synchronisers and rising-edge detect
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_rise
      if (g < LINES)
      begin : g_used
        assign req_rise[g] = req_sync_q[g] & ~req_prev_q[g];
      end
      else
      begin : g_unused
        assign req_rise[g] = 1'b0;
      end
    end
  endgenerate

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      req_meta_q <= {LINES{1'b0}};
      req_sync_q <= {LINES{1'b0}};
      req_prev_q <= {LINES{1'b0}};
    end
    else if (ce)
    begin
      req_meta_q <= request_lines;
      req_sync_q <= req_meta_q;
      req_prev_q <= req_sync_q;
    end
  end

  // ----------------------------------------------------------------------
  // Priority resolution over unmasked requests
  // ----------------------------------------------------------------------
  ipu_resolver u_resolver
  (
    .req       (irr_q & ~mask_q),
    .in_service_register       (isr_q),
    .lowest    (lowest_q),
    .special_masking_select       (smm_q),
    .win_valid (win_valid),
    .win_lvl   (win_lvl),
    .isr_valid (isr_valid),
    .isr_lvl   (isr_lvl)
  );

  // ----------------------------------------------------------------------
  // Command decode and next state
  // ----------------------------------------------------------------------
  always @*
  begin
    state_d    = state_q;
    need4_d    = need4_q;
    mask_d     = mask_q;
    lowest_d   = lowest_q;
    smm_d      = smm_q;
    read_sel_d = read_sel_q;
    poll_d     = poll_q;
    rot_auto_end_of_service_d = rot_auto_end_of_service_q;
    upm_d      = upm_q;
    auto_end_of_service_d     = auto_end_of_service_q;
    rdata_d    = rdata_q;
    irr_set    = req_rise;
    irr_clr    = 8'h00;
    isr_set    = 8'h00;
    isr_clr    = 8'h00;

    // Writes.
    if (wr_low && bus_wdata[`IPU_CW1_START_BIT])
    begin
      // Bits 1, 2 and 5 to 7 carry nothing for a single controller.
      state_d    = ST_SECOND;
      need4_d    = bus_wdata[`IPU_CW1_NEED4_BIT];
      mask_d     = `IPU_MASK_RST;
      lowest_d   = `IPU_LOWEST_RST;
      smm_d      = 1'b0;
      read_sel_d = `IPU_READ_IRR;
      poll_d     = 1'b0;
      rot_auto_end_of_service_d = 1'b0;
      if (!bus_wdata[`IPU_CW1_NEED4_BIT])
      begin
        upm_d  = 1'b0;
        auto_end_of_service_d = 1'b0;
      end
    end
    else if (wr_high && (state_q == ST_SECOND))
    begin
      // Value is ignored; the slave address stays fixed at its reset value.
      state_d = need4_q ? ST_FOURTH : ST_READY;
    end
    else if (wr_high && (state_q == ST_FOURTH))
    begin
      upm_d   = bus_wdata[`IPU_CW4_UPM_BIT];
      auto_end_of_service_d  = bus_wdata[`IPU_CW4_AUTO_END_OF_SERVICE_BIT];
      state_d = ST_READY;
    end
    else if (state_q == ST_READY)
    begin
      if (wr_high)
        mask_d = bus_wdata;
      else if (wr_low && bus_wdata[`IPU_OCW_SEL_BIT])
      begin
        if (bus_wdata[`IPU_MASK_MODE_READ_SELECT_WORD_SPECIAL_MASKING_WRITE_ENABLE_BIT])
          smm_d = bus_wdata[`IPU_MASK_MODE_READ_SELECT_WORD_SMM_BIT];
        if (bus_wdata[`IPU_MASK_MODE_READ_SELECT_WORD_POLL_BIT])
          poll_d = 1'b1;
        else if (bus_wdata[`IPU_MASK_MODE_READ_SELECT_WORD_RR_BIT])
          read_sel_d = bus_wdata[`IPU_MASK_MODE_READ_SELECT_WORD_RIS_BIT];
      end
      else if (wr_low)
      begin
        case (act)
          `IPU_ACT_NS_EOI:
          begin
            if (isr_valid)
              isr_clr = 8'h01 << isr_lvl;
          end
          `IPU_ACT_SP_EOI:
          begin
            isr_clr = 8'h01 << bus_wdata[2:0];
          end
          `IPU_ACT_ROT_NS_EOI:
          begin
            if (isr_valid)
            begin
              isr_clr  = 8'h01 << isr_lvl;
              lowest_d = isr_lvl;
            end
          end
          `IPU_ACT_ROT_AUTO_END_OF_SERVICE_SET:
          begin
            rot_auto_end_of_service_d = 1'b1;
          end
          `IPU_ACT_ROT_AUTO_END_OF_SERVICE_CLR:
          begin
            rot_auto_end_of_service_d = 1'b0;
          end
          `IPU_ACT_ROT_SP_EOI:
          begin
            isr_clr  = 8'h01 << bus_wdata[2:0];
            lowest_d = bus_wdata[2:0];
          end
          `IPU_ACT_SET_PRIO:
          begin
            lowest_d = bus_wdata[2:0];
          end
          default:
          begin
            lowest_d = lowest_q;
          end
        endcase
      end
    end

    // Reads.
    if (rd_low && poll_q)
    begin
      poll_d = 1'b0;
      if (win_valid)
      begin
        rdata_d = {1'b1, 4'h0, win_lvl};
        irr_clr = 8'h01 << win_lvl;
        if (!auto_end_of_service_q)
          isr_set = 8'h01 << win_lvl;
        else if (rot_auto_end_of_service_q)
          lowest_d = win_lvl;
      end
      else
        rdata_d = {1'b0, 4'h0, `IPU_NO_REQ_LEVEL};
    end
    else if (rd_low)
      rdata_d = (read_sel_q == `IPU_READ_ISR) ? isr_q : irr_q;
    else if (rd_high)
      rdata_d = mask_q;

    irr_d = (irr_q & ~irr_clr) | irr_set;
    isr_d = (isr_q & ~isr_clr) | isr_set;
    int_d = win_valid && (state_d == ST_READY);
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q    <= ST_IDLE;
      need4_q    <= 1'b0;
      mask_q     <= `IPU_MASK_RST;
      irr_q      <= 8'h00;
      isr_q      <= 8'h00;
      lowest_q   <= `IPU_LOWEST_RST;
      smm_q      <= 1'b0;
      read_sel_q <= `IPU_READ_IRR;
      poll_q     <= 1'b0;
      rot_auto_end_of_service_q <= 1'b0;
      upm_q      <= 1'b0;
      auto_end_of_service_q     <= 1'b0;
      rdata_q    <= 8'h00;
      int_q      <= 1'b0;
      done_q     <= 1'b0;
    end
    else if (ce)
    begin
      state_q    <= state_d;
      need4_q    <= need4_d;
      mask_q     <= mask_d;
      irr_q      <= irr_d;
      isr_q      <= isr_d;
      lowest_q   <= lowest_d;
      smm_q      <= smm_d;
      read_sel_q <= read_sel_d;
      poll_q     <= poll_d;
      rot_auto_end_of_service_q <= rot_auto_end_of_service_d;
      upm_q      <= upm_d;
      auto_end_of_service_q     <= auto_end_of_service_d;
      rdata_q    <= rdata_d;
      int_q      <= int_d;
      done_q     <= (state_d == ST_READY);
    end
  end

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------
  always @*
  begin
    bus_rdata           = rdata_q;
    int_out             = int_q;
    init_done           = done_q;
    processor_mode_bit  = upm_q;
    auto_end_of_service = auto_end_of_service_q;
  end

endmodule

//--- bench/ipu_core_assertions.sv
/*
  Checker of the interrupt priority unit, bound to ipu_core.
  Assumes one-cycle bus strobes and the one-cycle read answer of the core.
*/
`timescale 1ns/1ns
module ipu_core_checker
#(
  parameter LINES = 8
)
(
  input wire             clk,
  input wire             resetn,
  input wire             ce,
  input wire             bus_cs,
  input wire             bus_wr,
  input wire             bus_rd,
  input wire             bus_addr,
  input wire [7:0]       bus_wdata,
  input wire [7:0]       bus_rdata,
  input wire [LINES-1:0] request_lines,
  input wire             int_out,
  input wire             init_done,
  input wire             processor_mode_bit,
  input wire             auto_end_of_service
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_rdata_hold;
    !(bus_cs && bus_rd) |=> $stable(bus_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read byte moved without a read");

  property p_init_restart;
    bus_cs && bus_wr && !bus_addr && bus_wdata[4] |-> ##[1:2] !init_done;
  endproperty
  a_init_restart: assert property (p_init_restart) else $error("first word did not restart");

  property p_init_end;
    $rose(init_done) |-> $past(bus_cs && bus_wr && bus_addr)
      || $past(bus_cs && bus_wr && bus_addr, 2);
  endproperty
  a_init_end: assert property (p_init_end) else $error("init ended without a high write");

  property p_mode_cause;
    $changed(processor_mode_bit) || $changed(auto_end_of_service)
      |-> $past(bus_cs && bus_wr) || $past(bus_cs && bus_wr, 2);
  endproperty
  a_mode_cause: assert property (p_mode_cause) else $error("mode bits changed alone");

  property p_mask_read;
    bus_cs && bus_rd && bus_addr && $past(bus_cs && bus_wr && bus_addr && init_done, 2)
      |=> bus_rdata == $past(bus_wdata, 3);
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("mask read differs from write");

  property p_poll_form;
    bus_cs && bus_rd && !bus_addr
      && $past(bus_cs && bus_wr && !bus_addr && bus_wdata[4:2] == 3'h3, 2)
      |=> bus_rdata[6:3] == 4'h0 && (bus_rdata[7] || bus_rdata[2:0] == 3'h7);
  endproperty
  a_poll_form: assert property (p_poll_form) else $error("bad poll answer layout");

  property p_int_init;
    $rose(int_out) |-> init_done;
  endproperty
  a_int_init: assert property (p_int_init) else $error("interrupt before init done");

  property p_int_fall;
    $fell(int_out) |-> $past(bus_cs) || $past(bus_cs, 2) || $past(bus_cs, 3);
  endproperty
  a_int_fall: assert property (p_int_fall) else $error("interrupt dropped on its own");
endmodule

bind ipu_core ipu_core_checker #(.LINES(LINES)) chk_u (.clk(clk), .resetn(resetn), .ce(ce),
  .bus_cs(bus_cs), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .request_lines(request_lines),
  .int_out(int_out), .init_done(init_done), .processor_mode_bit(processor_mode_bit),
  .auto_end_of_service(auto_end_of_service));

//--- bench/ipu_host_model.sv
/*
  Host processor model: makes one byte transfer per call on the port bus.
  Assumes it is called just after a rising edge of clk or at time zero.
*/
`timescale 1ns/1ns
module ipu_host_model
(
  // Clock
  input  wire       clk,
  // Host byte bus
  output reg        bus_cs,
  output reg        bus_wr,
  output reg        bus_rd,
  output reg        bus_addr,
  output reg  [7:0] bus_wdata,
  input  wire [7:0] bus_rdata
);
  initial
  begin
    bus_cs = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = 1'b0;
    bus_wdata = 8'hA5;
  end

  // Released address and data lines show the inverse so that a stale value is never trusted.
  task xfer(input rd, input a, input [7:0] d, output [7:0] q);
  begin
    @(posedge clk);
    #1;
    bus_cs = 1'b1;
    bus_wr = !rd;
    bus_rd = rd;
    bus_addr = a;
    bus_wdata = d;
    @(posedge clk);
    #1;
    q = bus_rdata;
    bus_cs = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_addr = !a;
    bus_wdata = ~d;
  end
  endtask
endmodule

//--- bench/ipu_testbench.sv
/*
  Self-checking testbench of the interrupt priority unit.
  Assumes ipu_core, its checker and the host model are compiled before it.
*/
`timescale 1ns/1ns
module testbench;
  reg        clk;
  reg        resetn;
  reg        ce;
  reg  [7:0] req_pins;
  reg  [7:0] rv;
  wire       bus_cs;
  wire       bus_wr;
  wire       bus_rd;
  wire       bus_addr;
  wire [7:0] bus_wdata;
  wire [7:0] bus_rdata;
  wire       int_out;
  wire       init_done;
  wire       mode_bit;
  wire       auto_end_of_service_bit;
  integer    failures;
  integer    total_checks;

  always #10 clk = ~clk;

  ipu_host_model host_u (.clk(clk), .bus_cs(bus_cs), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));
  ipu_core dut_u (.clk(clk), .resetn(resetn), .ce(ce), .bus_cs(bus_cs), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .request_lines(req_pins), .int_out(int_out), .init_done(init_done),
    .processor_mode_bit(mode_bit), .auto_end_of_service(auto_end_of_service_bit));

  task check(input [8*6-1:0] what, input [7:0] seen, input [7:0] exp);
  begin
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("BAD %0s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  task final_report;
  begin
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  task wr(input a, input [7:0] d);
    host_u.xfer(1'b0, a, d, rv);
  endtask

  task rd(input a);
    host_u.xfer(1'b1, a, 8'h00, rv);
  endtask

  task tick;
  begin
    @(posedge clk);
    #1;
  end
  endtask

  task pins(input [7:0] v);
  begin
    tick;
    req_pins = v;
  end
  endtask

  task flags(input [2:0] exp);
  begin
    tick;
    check("flags", {5'h00, init_done, mode_bit, auto_end_of_service_bit}, {5'h00, exp});
  end
  endtask

  task pollchk(input [7:0] p, input [7:0] exp);
  begin
    wr(1'b0, p);
    rd(1'b0);
    check("poll", rv, exp);
  end
  endtask

  task statchk(input status_source_select, input [7:0] exp);
  begin
    wr(1'b0, {7'h05, status_source_select});
    rd(1'b0);
    check("status", rv, exp);
  end
  endtask

  task wait_int;
    integer i;
  begin
    i = 0;
    while (int_out !== 1'b1 && i < 20)
    begin
      tick;
      i = i + 1;
    end
    check("int", {7'h00, int_out}, 8'h01);
    if (int_out !== 1'b1)
      final_report;
  end
  endtask

  task t_init;
  begin
    wr(1'b0, 8'h13);
    wr(1'b1, 8'h55);
    flags(3'h0);
    wr(1'b1, 8'h03);
    flags(3'h7);
    wr(1'b0, 8'hF6);
    flags(3'h0);
    wr(1'b1, 8'hAA);
    flags(3'h4);
    wr(1'b0, 8'h13);
    wr(1'b1, 8'h00);
    wr(1'b1, 8'h01);
    flags(3'h6);
    $display("test init done");
  end
  endtask

  task t_mask;
  begin
    wr(1'b1, 8'hC5);
    rd(1'b1);
    check("mask", rv, 8'hC5);
    wr(1'b0, 8'h13);
    wr(1'b1, 8'h00);
    wr(1'b1, 8'h01);
    rd(1'b1);
    check("mask", rv, 8'h00);
    wr(1'b1, 8'hC0);
    ce = 1'b0;
    wr(1'b1, 8'hFF);
    ce = 1'b1;
    tick;
    rd(1'b1);
    check("mask", rv, 8'hC0);
    $display("test mask done");
  end
  endtask

  task t_poll;
  begin
    pins(8'h24);
    wait_int;
    pollchk(8'h0C, 8'h82);
    tick;
    tick;
    check("int", {7'h00, int_out}, 8'h00);
    statchk(1'b1, 8'h04);
    statchk(1'b0, 8'h20);
    wr(1'b0, 8'h68);
    pollchk(8'h0E, 8'h85);
    wr(1'b0, 8'h48);
    wr(1'b0, 8'h20);
    statchk(1'b1, 8'h20);
    wr(1'b0, 8'h65);
    statchk(1'b1, 8'h00);
    $display("test poll done");
  end
  endtask

  task t_rot;
  begin
    pins(8'h00);
    wr(1'b0, 8'hC4);
    pins(8'h22);
    wait_int;
    pollchk(8'h0C, 8'h85);
    wr(1'b0, 8'hE5);
    statchk(1'b1, 8'h00);
    pollchk(8'h0C, 8'h81);
    wr(1'b0, 8'hA0);
    statchk(1'b1, 8'h00);
    pins(8'h00);
    pins(8'h05);
    wait_int;
    pollchk(8'h0C, 8'h82);
    wr(1'b0, 8'h62);
    pollchk(8'h0C, 8'h80);
    wr(1'b0, 8'h60);
    pollchk(8'h0C, 8'h07);
    $display("test rotate done");
  end
  endtask

  task t_auto_end_of_service;
  begin
    wr(1'b0, 8'h13);
    wr(1'b1, 8'h00);
    wr(1'b1, 8'h03);
    wr(1'b1, 8'hC0);
    wr(1'b0, 8'h80);
    pins(8'h00);
    pins(8'h02);
    wait_int;
    pollchk(8'h0C, 8'h81);
    statchk(1'b1, 8'h00);
    pins(8'h00);
    pins(8'h05);
    wait_int;
    pollchk(8'h0C, 8'h82);
    wr(1'b0, 8'h00);
    pollchk(8'h0C, 8'h80);
    pins(8'h00);
    pins(8'h0A);
    wait_int;
    pollchk(8'h0C, 8'h83);
    $display("test auto end done");
  end
  endtask

  initial
  begin
    clk = 1'b0;
    resetn = 1'b0;
    ce = 1'b1;
    req_pins = 8'h00;
    rv = 8'h00;
    failures = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_init;
    t_mask;
    t_poll;
    t_rot;
    t_auto_end_of_service;
    final_report;
  end
endmodule
